/* File: pkg/serial_pkg.sv */
// constants shared by both ends of the serial link
package serial_pkg;
   // ==========================================
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_DATA = 8'h21;
   localparam logic [7:0] IDX_CTRL = 8'h22;
   localparam logic [7:0] IDX_CSR = 8'h23;
   localparam logic [1:0] BYTE_SHIFT = 2'h2;
   // ==========================================
   // serial_control_reg fields
   localparam int CTL_IRQ_EN = 7;
   localparam int CTL_PORT_EN = 6;
   localparam int CTL_DIV_EN = 5;
   localparam int CTL_MASTER = 4;
   localparam int CTL_IDLE_LVL = 3;
   localparam int CTL_PHASE = 2;
   localparam int CTL_RATE_HI = 1;
   localparam int CTL_RATE_LO = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // ==========================================
   // serial_control_status_reg fields
   localparam int CSR_DONE = 7;
   localparam int CSR_WRITE_COLLISION_FLAG = 6;
   localparam int CSR_OVR = 5;
   localparam int CSR_MODE_FAULT_FLAG = 4;
   localparam int CSR_OUT_DIS = 2;
   localparam int CSR_SOFT_MGT = 1;
   localparam int CSR_SOFT_LVL = 0;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] CSR_SW_MASK = 8'h07;
   // ==========================================
   // bit count of one byte and the sck half period per rate code
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [4:0] LAST_EDGE = 5'h0f;
   function automatic logic [6:0] half_period(input logic [2:0] code);
      unique case (code)
         3'h4: half_period = 7'h02;
         3'h0: half_period = 7'h04;
         3'h1: half_period = 7'h08;
         3'h6: half_period = 7'h10;
         3'h2: half_period = 7'h20;
         default: half_period = 7'h40;
      endcase
   endfunction : half_period
endpackage : serial_pkg

/* File: pkg/serial_link_if.sv */
// four-wire serial link joining the peripheral end and the partner end
`timescale 1ns/100ps
interface serial_link_if;
   // ==========================================
   // peripheral drives; enables are active low
   logic dev_sck_o;
   logic dev_sck_oe_n;
   logic dev_mosi_o;
   logic dev_mosi_oe_n;
   logic dev_miso_o;
   logic dev_miso_oe_n;
   // ==========================================
   // partner drives
   logic ptr_sck_o;
   logic ptr_sck_oe_n;
   logic ptr_mosi_o;
   logic ptr_mosi_oe_n;
   logic ptr_miso_o;
   logic ptr_miso_oe_n;
   logic ss_n;
   // ==========================================
   // resolved wire levels; undriven lines fall to a weak low
   logic sck;
   logic mosi;
   logic miso;
   assign sck = !dev_sck_oe_n ? dev_sck_o : (!ptr_sck_oe_n ? ptr_sck_o : 1'b0);
   assign mosi = !dev_mosi_oe_n ? dev_mosi_o : (!ptr_mosi_oe_n ? ptr_mosi_o : 1'b0);
   assign miso = !dev_miso_oe_n ? dev_miso_o : (!ptr_miso_oe_n ? ptr_miso_o : 1'b0);

   modport periph (
      output dev_sck_o, dev_sck_oe_n, dev_mosi_o, dev_mosi_oe_n, dev_miso_o, dev_miso_oe_n,
      input sck, mosi, miso, ss_n
   );
   modport partner (
      output ptr_sck_o, ptr_sck_oe_n, ptr_mosi_o, ptr_mosi_oe_n, ptr_miso_o, ptr_miso_oe_n,
      output ss_n,
      input sck, mosi, miso
   );
endinterface : serial_link_if

/* File: src/serial_periph.sv */
// serial peripheral end: AHB-Lite registers, shifter, low-power wake logic
// Functional notes
// - wait mode: keep running, events exit wait
// - halt freezes registers, block inactive until wake unless a slave selected at halt entry
// - several bytes during halt raise overrun
// - slave done wakes halt; fault/overrun do not
// - halt wake only if select low at entry
// - partner holds select pin low during halt
// - extra byte after wake restores normal state
// - done, fault, overrun share one masked request; write collision does not
// - interrupt enable gates done, fault, overrun
// - port enable connects pins, fault clears it
// - three rate bits pick master sck divider
// - divider enable resets; rates ignored in slave
// - master select drives sck, swaps data pins
// - idle level bit sets sck idle level
// - software disables port before idle change
// - phase bit picks first or second capture
// - partner uses identical idle and phase settings
// - control resets upper four bits cleared
// - status layout bits seven to zero, resets zero
// - master selects only one slave at once
// - unwritten slave echoes the received byte
// - select low in master mode flags fault
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
module serial_periph (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // cpu low-power state and interrupt
   input wire logic CPU_HALT,
   input wire logic CPU_IRQ_MASK,
   output logic IRQ,
   output logic WAKE_WAIT,
   output logic WAKE_HALT,
   output logic LOWPWR_STATE,
   // serial link
   serial_link_if.periph link
);
   // ==========================================
   // registers and flags
   logic [7:0] ctl_ff;
   logic [2:0] csr_sw_ff;
   logic done_ff, write_collision_flag_ff, ovr_ff, mode_fault_flag_ff;
   logic done_arm_ff, write_collision_flag_arm_ff, mode_fault_flag_arm_ff;
   logic [7:0] rxbuf_ff;
   logic [7:0] sr_ff;
   logic out_ff;
   logic [2:0] bitcnt_ff;
   logic run_ff;
   logic sck_ff;
   logic [6:0] half_ff;
   logic [4:0] edge_ff;
   logic sck_prev_ff;
   logic ss_prev_ff;
   logic halt_prev_ff;
   logic halt_ok_ff;
   logic lowpwr_ff;
   // bus state
   logic ph_valid_ff, ph_write_ff;
   logic [7:0] ph_idx_ff;
   logic [31:0] hrdata_ff;

   // ==========================================
   // decoded controls
   logic irq_en, port_en, master, idle_lvl, phase;
   logic ss_eff, active, halted;
   assign irq_en = ctl_ff[serial_pkg::CTL_IRQ_EN];
   assign port_en = ctl_ff[serial_pkg::CTL_PORT_EN];
   assign master = ctl_ff[serial_pkg::CTL_MASTER];
   assign idle_lvl = ctl_ff[serial_pkg::CTL_IDLE_LVL];
   assign phase = ctl_ff[serial_pkg::CTL_PHASE];
   assign ss_eff = csr_sw_ff[serial_pkg::CSR_SOFT_MGT] ?
                   csr_sw_ff[serial_pkg::CSR_SOFT_LVL] : link.ss_n;
   assign halted = CPU_HALT;
   // in halt only a slave selected at halt entry keeps shifting
   assign active = !halted || (halt_ok_ff && !master);

   // ==========================================
   // AHB-Lite slave: zero wait states, always OKAY
   logic addr_take;
   logic [7:0] addr_idx;
   logic rd_csr, rd_data, wr_data, wr_ctl, wr_csr;
   assign addr_take = HSEL && HTRANS[1] && HREADY;
   assign addr_idx = HADDR[9:2];
   assign rd_csr = addr_take && !HWRITE && addr_idx == serial_pkg::IDX_CSR;
   assign rd_data = addr_take && !HWRITE && addr_idx == serial_pkg::IDX_DATA;
   // writes are dropped while halted so the registers stay frozen
   assign wr_data = ph_valid_ff && ph_write_ff && !halted &&
                    ph_idx_ff == serial_pkg::IDX_DATA;
   assign wr_ctl = ph_valid_ff && ph_write_ff && !halted && ph_idx_ff == serial_pkg::IDX_CTRL;
   assign wr_csr = ph_valid_ff && ph_write_ff && !halted && ph_idx_ff == serial_pkg::IDX_CSR;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = hrdata_ff;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ph_valid_ff <= 1'b0;
         ph_write_ff <= 1'b0;
         ph_idx_ff <= 8'h00;
      end else begin
         ph_valid_ff <= addr_take;
         ph_write_ff <= HWRITE;
         ph_idx_ff <= addr_idx;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (addr_take && !HWRITE) begin
         unique case (addr_idx)
            serial_pkg::IDX_DATA: hrdata_ff <= {24'h000000, rxbuf_ff};
            serial_pkg::IDX_CTRL: hrdata_ff <= {24'h000000, ctl_ff};
            // reserved bit three always reads zero
            serial_pkg::IDX_CSR: hrdata_ff <= {24'h000000, done_ff, write_collision_flag_ff, ovr_ff, mode_fault_flag_ff,
                                               1'b0, csr_sw_ff};
            default: hrdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================
   // shift strobes, master clock and slave edge detect
   logic [6:0] half_max;
   logic tick, lead, trail, sample_ev, shift_ev, din, byte_done, busy, start;
   logic mode_fault_flag_ev, wr_ok;
   // rate bits only matter for the master's own divider
   assign half_max = serial_pkg::half_period({ctl_ff[serial_pkg::CTL_DIV_EN],
                     ctl_ff[serial_pkg::CTL_RATE_HI], ctl_ff[serial_pkg::CTL_RATE_LO]});
   assign tick = master && run_ff && !halted && half_ff == half_max - 7'h01;
   always_comb begin
      if (master) begin
         lead = tick && !edge_ff[0];
         trail = tick && edge_ff[0];
      end else begin
         lead = active && port_en && !ss_eff && link.sck != sck_prev_ff &&
                sck_prev_ff == idle_lvl;
         trail = active && port_en && !ss_eff && link.sck != sck_prev_ff &&
                 sck_prev_ff != idle_lvl;
      end
   end
   assign sample_ev = phase ? trail : lead;
   assign shift_ev = phase ? lead : trail;
   assign din = master ? link.miso : link.mosi;
   assign byte_done = sample_ev && bitcnt_ff == serial_pkg::LAST_BIT;
   assign busy = master ? run_ff : (bitcnt_ff != 3'h0 || (!phase && !ss_eff && port_en));
   // data writes wait for a status read once the done flag is up
   assign wr_ok = wr_data && (!done_ff || done_arm_ff) && !busy;
   assign start = wr_ok && master && port_en;
   assign mode_fault_flag_ev = master && !ss_eff && active;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         half_ff <= 7'h00;
         edge_ff <= 5'h00;
         run_ff <= 1'b0;
         sck_ff <= 1'b0;
      end else if (start) begin
         half_ff <= 7'h00;
         edge_ff <= 5'h00;
         run_ff <= 1'b1;
         sck_ff <= idle_lvl;
      end else if (!run_ff || !master) begin
         run_ff <= 1'b0;
         sck_ff <= idle_lvl;
      end else if (!halted) begin
         half_ff <= tick ? 7'h00 : half_ff + 7'h01;
         if (tick) begin
            sck_ff <= !sck_ff;
            edge_ff <= edge_ff + 5'h01;
            if (edge_ff == serial_pkg::LAST_EDGE) begin
               run_ff <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         sck_prev_ff <= 1'b0;
         ss_prev_ff <= 1'b1;
      end else if (active) begin
         sck_prev_ff <= link.sck;
         ss_prev_ff <= ss_eff;
      end
   end

   // ==========================================
   // shift register; without a new write it returns what it received
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sr_ff <= 8'h00;
         out_ff <= 1'b0;
         bitcnt_ff <= 3'h0;
      end else if (wr_ok) begin
         sr_ff <= HWDATA[7:0];
         out_ff <= HWDATA[7];
         bitcnt_ff <= 3'h0;
      end else if (!master && ss_eff) begin
         bitcnt_ff <= 3'h0;
         if (!ss_prev_ff) begin
            out_ff <= sr_ff[7];
         end
      end else begin
         if (sample_ev) begin
            sr_ff <= {sr_ff[6:0], din};
            bitcnt_ff <= bitcnt_ff + 3'h1;
         end
         if (shift_ev) begin
            out_ff <= sr_ff[7];
         end
      end
   end

   // ==========================================
   // control register; fault forces slave and disconnects pins
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctl_ff <= serial_pkg::CTL_RESET;
         csr_sw_ff <= serial_pkg::CSR_RESET[2:0];
      end else begin
         if (wr_ctl) begin
            ctl_ff <= HWDATA[7:0];
            if (mode_fault_flag_ff && !mode_fault_flag_arm_ff) begin
               ctl_ff[serial_pkg::CTL_PORT_EN] <= 1'b0;
               ctl_ff[serial_pkg::CTL_MASTER] <= 1'b0;
            end
         end
         if (wr_csr) begin
            csr_sw_ff <= HWDATA[2:0] & serial_pkg::CSR_SW_MASK[2:0];
         end
         if (mode_fault_flag_ev) begin
            ctl_ff[serial_pkg::CTL_PORT_EN] <= 1'b0;
            ctl_ff[serial_pkg::CTL_MASTER] <= 1'b0;
         end
      end
   end

   // ==========================================
   // event flags; a set in the clearing cycle wins
   always_ff @(posedge CLK) begin
      if (RESET) begin
         done_ff <= 1'b0;
         done_arm_ff <= 1'b0;
         ovr_ff <= 1'b0;
         rxbuf_ff <= 8'h00;
      end else begin
         if (rd_csr) begin
            done_arm_ff <= done_ff;
         end else if ((rd_data || wr_data) && done_arm_ff) begin
            done_arm_ff <= 1'b0;
         end
         if (byte_done) begin
            done_ff <= 1'b1;
            // a second byte before the flag clears is an overrun, buffer kept
            if (done_ff) begin
               ovr_ff <= 1'b1;
            end else begin
               rxbuf_ff <= {sr_ff[6:0], din};
            end
         end else begin
            if ((rd_data || wr_data) && done_arm_ff) begin
               done_ff <= 1'b0;
            end
            if (rd_csr) begin
               ovr_ff <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         write_collision_flag_ff <= 1'b0;
         write_collision_flag_arm_ff <= 1'b0;
         mode_fault_flag_ff <= 1'b0;
         mode_fault_flag_arm_ff <= 1'b0;
      end else begin
         write_collision_flag_arm_ff <= rd_csr ? write_collision_flag_ff : (rd_data ? 1'b0 : write_collision_flag_arm_ff);
         if (wr_data && busy && (!done_ff || done_arm_ff)) begin
            write_collision_flag_ff <= 1'b1;
         end else if (rd_data && write_collision_flag_arm_ff) begin
            write_collision_flag_ff <= 1'b0;
         end
         mode_fault_flag_arm_ff <= rd_csr ? mode_fault_flag_ff : (wr_ctl ? 1'b0 : mode_fault_flag_arm_ff);
         if (mode_fault_flag_ev) begin
            mode_fault_flag_ff <= 1'b1;
         end else if (wr_ctl && mode_fault_flag_arm_ff) begin
            mode_fault_flag_ff <= 1'b0;
         end
      end
   end

   // ==========================================
   // halt entry capture and post-wake state
   always_ff @(posedge CLK) begin
      if (RESET) begin
         halt_prev_ff <= 1'b0;
         halt_ok_ff <= 1'b0;
         lowpwr_ff <= 1'b0;
      end else begin
         halt_prev_ff <= CPU_HALT;
         if (CPU_HALT && !halt_prev_ff) begin
            halt_ok_ff <= !ss_eff;
            lowpwr_ff <= 1'b1;
         end else if (master || (!halted && byte_done)) begin
            lowpwr_ff <= 1'b0;
         end
      end
   end

   // ==========================================
   // shared request, wait and halt wake
   logic req;
   assign req = irq_en && (done_ff || mode_fault_flag_ff || ovr_ff);
   assign IRQ = req && !CPU_IRQ_MASK;
   assign WAKE_WAIT = IRQ;
   assign WAKE_HALT = halted && halt_ok_ff && !master && irq_en && done_ff &&
                      !CPU_IRQ_MASK;
   assign LOWPWR_STATE = lowpwr_ff;

   // ==========================================
   // pin drive; enables are active low
   assign link.dev_sck_o = sck_ff;
   assign link.dev_sck_oe_n = !(port_en && master);
   assign link.dev_mosi_o = out_ff;
   assign link.dev_mosi_oe_n = !(port_en && master && !csr_sw_ff[serial_pkg::CSR_OUT_DIS]);
   assign link.dev_miso_o = out_ff;
   assign link.dev_miso_oe_n = !(port_en && !master && !ss_eff &&
                                 !csr_sw_ff[serial_pkg::CSR_OUT_DIS]);
endmodule : serial_periph

/* File: src/serial_partner.sv */
// partner end of the serial link: simple master or slave under user control
`timescale 1ns/100ps
module serial_partner (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // settings; must match the peripheral's idle level and phase
   input wire logic MASTER_MODE,
   input wire logic CLOCK_IDLE_LEVEL_BIT,
   input wire logic CAPTURE_PHASE_BIT,
   input wire logic [6:0] HALF_PERIOD,
   // select lines
   input wire logic SS_OUT_N,
   input wire logic SEL_N,
   // byte request and answer
   input wire logic START,
   input wire logic [7:0] TX_DATA,
   output logic BUSY,
   output logic DONE,
   output logic [7:0] RX_DATA,
   // serial link
   serial_link_if.partner link
);
   logic [7:0] sr_ff;
   logic [7:0] rx_ff;
   logic out_ff, run_ff, sck_ff, sck_prev_ff, done_ff;
   logic [6:0] half_ff;
   logic [4:0] edge_ff;
   logic [2:0] bitcnt_ff;
   logic tick, lead, trail, sample_ev, shift_ev, din, load;

   // ==========================================
   // edge strobes from own clock or from the peripheral's
   assign tick = MASTER_MODE && run_ff && half_ff >= HALF_PERIOD - 7'h01;
   always_comb begin
      if (MASTER_MODE) begin
         lead = tick && !edge_ff[0];
         trail = tick && edge_ff[0];
      end else begin
         lead = !SEL_N && link.sck != sck_prev_ff && sck_prev_ff == CLOCK_IDLE_LEVEL_BIT;
         trail = !SEL_N && link.sck != sck_prev_ff && sck_prev_ff != CLOCK_IDLE_LEVEL_BIT;
      end
   end
   assign sample_ev = CAPTURE_PHASE_BIT ? trail : lead;
   assign shift_ev = CAPTURE_PHASE_BIT ? lead : trail;
   assign din = MASTER_MODE ? link.miso : link.mosi;
   // a new byte, including the extra one after a halt wake, starts only when idle
   assign load = START && !BUSY;
   assign BUSY = MASTER_MODE ? run_ff : bitcnt_ff != 3'h0;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         half_ff <= 7'h00;
         edge_ff <= 5'h00;
         run_ff <= 1'b0;
         sck_ff <= 1'b0;
      end else if (load && MASTER_MODE) begin
         half_ff <= 7'h00;
         edge_ff <= 5'h00;
         run_ff <= 1'b1;
         sck_ff <= CLOCK_IDLE_LEVEL_BIT;
      end else if (!run_ff) begin
         sck_ff <= CLOCK_IDLE_LEVEL_BIT;
      end else begin
         half_ff <= tick ? 7'h00 : half_ff + 7'h01;
         if (tick) begin
            sck_ff <= !sck_ff;
            edge_ff <= edge_ff + 5'h01;
            if (edge_ff == serial_pkg::LAST_EDGE) begin
               run_ff <= 1'b0;
            end
         end
      end
   end

   // ==========================================
   // shifter and completion pulse
   always_ff @(posedge CLK) begin
      if (RESET) begin
         sr_ff <= 8'h00;
         rx_ff <= 8'h00;
         out_ff <= 1'b0;
         bitcnt_ff <= 3'h0;
         done_ff <= 1'b0;
         sck_prev_ff <= 1'b0;
      end else begin
         sck_prev_ff <= link.sck;
         done_ff <= sample_ev && bitcnt_ff == serial_pkg::LAST_BIT;
         if (load) begin
            sr_ff <= TX_DATA;
            out_ff <= TX_DATA[7];
            bitcnt_ff <= 3'h0;
         end else begin
            if (sample_ev) begin
               sr_ff <= {sr_ff[6:0], din};
               bitcnt_ff <= bitcnt_ff + 3'h1;
               if (bitcnt_ff == serial_pkg::LAST_BIT) begin
                  rx_ff <= {sr_ff[6:0], din};
               end
            end
            if (shift_ev) begin
               out_ff <= sr_ff[7];
            end
         end
      end
   end
   assign DONE = done_ff;
   assign RX_DATA = rx_ff;

   // ==========================================
   // pins; the user keeps one slave selected and the select low over halt
   assign link.ss_n = SS_OUT_N;
   assign link.ptr_sck_o = sck_ff;
   assign link.ptr_sck_oe_n = !MASTER_MODE;
   assign link.ptr_mosi_o = out_ff;
   assign link.ptr_mosi_oe_n = !MASTER_MODE;
   assign link.ptr_miso_o = out_ff;
   assign link.ptr_miso_oe_n = MASTER_MODE || SEL_N;
endmodule : serial_partner

/* File: bench/serial_link_asserts.sv */
// link wire checks for both serial ends
`timescale 1ns/100ps
module serial_link_asserts (
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // link wires
   input wire logic dev_sck_o,
   input wire logic dev_sck_oe_n,
   input wire logic dev_mosi_oe_n,
   input wire logic dev_miso_oe_n,
   input wire logic ptr_sck_oe_n,
   input wire logic ptr_miso_oe_n,
   input wire logic ss_n
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);
   // ==========================================
   // ownership of the wires
   a_sck_one_driver: assert property (dev_sck_oe_n || ptr_sck_oe_n)
      else $error("sck driven twice");
   a_miso_one_driver: assert property (dev_miso_oe_n || ptr_miso_oe_n)
      else $error("miso driven twice");
   a_master_frees_miso: assert property (!dev_sck_oe_n |-> dev_miso_oe_n)
      else $error("master drives miso");
   a_mosi_only_master: assert property (!dev_mosi_oe_n |-> !dev_sck_oe_n)
      else $error("slave drives mosi");
   // two settle cycles allowed after the select line rises
   a_miso_needs_select: assert property (
      ss_n && $past(ss_n) && $past(ss_n, 2) |-> dev_miso_oe_n)
      else $error("unselected slave drives miso");
   // ==========================================
   // timing and fault reaction
   a_fault_drops_sck: assert property (!dev_sck_oe_n && !ss_n |-> ##[1:8] dev_sck_oe_n)
      else $error("master kept sck after select low");
   a_sck_half_min: assert property (
      !dev_sck_oe_n && !$past(dev_sck_oe_n) && $changed(dev_sck_o) |=> $stable(dev_sck_o))
      else $error("sck half period below two cycles");
   a_reset_frees_pins: assert property (
      $fell(RESET) |-> dev_sck_oe_n && dev_mosi_oe_n && dev_miso_oe_n)
      else $error("pins driven after reset");
endmodule : serial_link_asserts

/* File: bench/spi_ctrl_lowpower_irq_tb.sv */
// bench joining both link ends, driving the register port and the partner
`timescale 1ns/100ps
module spi_ctrl_lowpower_irq_tb;
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] dtx;
      logic [7:0] ptx;
      logic [6:0] half;
   } row_type;
   localparam logic [7:0] DR = serial_pkg::IDX_DATA;
   localparam logic [7:0] CR = serial_pkg::IDX_CTRL;
   localparam logic [7:0] SR = serial_pkg::IDX_CSR;
   // ==========================================
   // rate codes, both modes, all idle level and phase pairs
   row_type rows [8] = '{'{8'h70, 8'ha5, 8'h3c, 7'h02}, '{8'h58, 8'h81, 8'h7e, 7'h04},
      '{8'h47, 8'h01, 8'h80, 7'h03}, '{8'h55, 8'hff, 8'h00, 7'h08},
      '{8'h7e, 8'h5a, 8'hc3, 7'h10}, '{8'h6a, 8'h96, 8'h69, 7'h05},
      '{8'h52, 8'h12, 8'hed, 7'h20}, '{8'h5b, 8'hc4, 8'h2b, 7'h40}};
   logic CLK = 1'b0, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, CPU_HALT = 1'b0;
   logic CPU_IRQ_MASK = 1'b0, MASTER_MODE = 1'b0, CLOCK_IDLE_LEVEL_BIT = 1'b0, CAPTURE_PHASE_BIT = 1'b0, START = 1'b0;
   logic SS_OUT_N = 1'b1, SEL_N = 1'b1, HREADYOUT, HRESP, IRQ, WAKE_WAIT, WAKE_HALT;
   logic LOWPWR_STATE, BUSY, DONE, last_sck;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
   logic [1:0] HTRANS = 2'h0;
   logic [6:0] HALF_PERIOD = 7'h02;
   logic [7:0] TX_DATA = 8'h00, RX_DATA, rd;
   int n_errors = 0, tests_run = 0, n_edges = 0, t_first = 0, t_last = 0, cyc = 0;
   always #2.5 CLK = !CLK;
   serial_link_if u_serial_link_if ();
   serial_periph u_serial_periph (.CLK(CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CPU_HALT(CPU_HALT),
      .CPU_IRQ_MASK(CPU_IRQ_MASK), .IRQ(IRQ), .WAKE_WAIT(WAKE_WAIT), .WAKE_HALT(WAKE_HALT),
      .LOWPWR_STATE(LOWPWR_STATE), .link(u_serial_link_if));
   serial_partner u_serial_partner (.CLK(CLK), .RESET(RESET), .MASTER_MODE(MASTER_MODE),
      .CLOCK_IDLE_LEVEL_BIT(CLOCK_IDLE_LEVEL_BIT), .CAPTURE_PHASE_BIT(CAPTURE_PHASE_BIT), .HALF_PERIOD(HALF_PERIOD), .SS_OUT_N(SS_OUT_N), .SEL_N(SEL_N),
      .START(START), .TX_DATA(TX_DATA), .BUSY(BUSY), .DONE(DONE), .RX_DATA(RX_DATA),
      .link(u_serial_link_if));
   serial_link_asserts u_serial_link_asserts (.CLK(CLK), .RESET(RESET),
      .dev_sck_o(u_serial_link_if.dev_sck_o), .dev_sck_oe_n(u_serial_link_if.dev_sck_oe_n),
      .dev_mosi_oe_n(u_serial_link_if.dev_mosi_oe_n),
      .dev_miso_oe_n(u_serial_link_if.dev_miso_oe_n),
      .ptr_sck_oe_n(u_serial_link_if.ptr_sck_oe_n),
      .ptr_miso_oe_n(u_serial_link_if.ptr_miso_oe_n), .ss_n(u_serial_link_if.ss_n));
   // ==========================================
   // sck edge counter on the resolved wire
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      last_sck <= u_serial_link_if.sck;
      if (u_serial_link_if.sck !== last_sck) begin
         n_edges <= n_edges + 1;
         t_last <= cyc;
         if (n_edges == 0) t_first <= cyc;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      if (n_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= wr;
      HADDR <= {22'h0, idx, 2'h0};
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= {24'h0, wd};
      @(posedge CLK);
      while (HREADYOUT !== 1'b1) @(posedge CLK);
      rd = HRDATA[7:0];
      check(HRESP, 1'b0);
   endtask : bus
   task automatic poll(input logic [7:0] mask);
      rd = 8'h00;
      while ((rd & mask) == 8'h00) bus(1'b0, SR, 8'h00);
   endtask : poll
   task automatic kick(input logic [7:0] b);
      TX_DATA <= b;
      START <= 1'b1;
      @(posedge CLK);
      START <= 1'b0;
   endtask : kick
   task automatic xfer(input logic [7:0] b);
      kick(b);
      @(posedge CLK);
      while (BUSY !== 1'b0) @(posedge CLK);
      @(posedge CLK);
   endtask : xfer
   initial begin
      repeat (40000) @(posedge CLK);
      n_errors++;
      end_sim();
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (6) @(posedge CLK);
      RESET <= 1'b0;
      @(posedge CLK);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, CR, 8'h00);
         MASTER_MODE <= !rows[i].ctl[4];
         CLOCK_IDLE_LEVEL_BIT <= rows[i].ctl[3];
         CAPTURE_PHASE_BIT <= rows[i].ctl[2];
         HALF_PERIOD <= rows[i].half;
         // selects stay high while sck settles; a phase 0 slave also needs it to load data
         SEL_N <= 1'b1;
         SS_OUT_N <= 1'b1;
         bus(1'b1, CR, rows[i].ctl);
         // enabling moves sck to its idle level; let that pass before counting
         repeat (3) @(negedge CLK);
         n_edges = 0;
         @(posedge CLK);
         if (!rows[i].ctl[4]) bus(1'b1, DR, rows[i].dtx);
         SEL_N <= !rows[i].ctl[4];
         SS_OUT_N <= rows[i].ctl[4];
         kick(rows[i].ptx);
         if (rows[i].ctl[4]) bus(1'b1, DR, rows[i].dtx);
         poll(8'h80);
         check(rd, 8'h80);
         bus(1'b0, DR, 8'h00);
         check(rd, rows[i].ptx);
         while (n_edges < 16 || BUSY === 1'b1) @(posedge CLK);
         check(RX_DATA, rows[i].dtx);
         check(n_edges, 16);
         check(t_last - t_first, 15 * rows[i].half);
         check(u_serial_link_if.sck, rows[i].ctl[3]);
      end
      RESET <= 1'b1;
      repeat (2) @(posedge CLK);
      RESET <= 1'b0;
      @(posedge CLK);
      bus(1'b0, CR, 8'h00);
      check(rd & 8'hf0, 8'h00);
      bus(1'b0, SR, 8'h00);
      check(rd, serial_pkg::CSR_RESET);
      bus(1'b1, SR, 8'hff);
      bus(1'b0, SR, 8'h00);
      check(rd, 8'h07);
      bus(1'b0, 8'h30, 8'h00);
      check(rd, 8'h00);
      bus(1'b1, SR, 8'h00);
      bus(1'b1, CR, 8'hd0);
      SS_OUT_N <= 1'b0;
      poll(8'h10);
      check(rd, 8'h10);
      check(IRQ, 1'b1);
      check(WAKE_WAIT, 1'b1);
      check(WAKE_HALT, 1'b0);
      CPU_IRQ_MASK <= 1'b1;
      SS_OUT_N <= 1'b1;
      bus(1'b0, CR, 8'h00);
      check(rd & 8'h50, 8'h00);
      check(IRQ, 1'b0);
      CPU_IRQ_MASK <= 1'b0;
      bus(1'b1, CR, 8'h00);
      MASTER_MODE <= 1'b1;
      CAPTURE_PHASE_BIT <= 1'b1;
      CLOCK_IDLE_LEVEL_BIT <= 1'b0;
      HALF_PERIOD <= 7'h02;
      SS_OUT_N <= 1'b0;
      bus(1'b1, CR, 8'hc4);
      CPU_HALT <= 1'b1;
      xfer(8'h5a);
      xfer(8'h3c);
      check(RX_DATA, 8'h5a);
      check(WAKE_HALT, 1'b1);
      check(LOWPWR_STATE, 1'b1);
      bus(1'b1, CR, 8'h00);
      bus(1'b0, CR, 8'h00);
      check(rd, 8'hc4);
      CPU_HALT <= 1'b0;
      bus(1'b0, SR, 8'h00);
      check(rd, 8'ha0);
      bus(1'b0, DR, 8'h00);
      check(rd, 8'h5a);
      xfer(8'h11);
      check(LOWPWR_STATE, 1'b0);
      end_sim();
   end
endmodule : spi_ctrl_lowpower_irq_tb
